// [hrb_pkg.sv]
package hrb_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int NREG = 8;
  localparam int BYTE_W = 8;
  localparam logic [2:0] LC_RX_STAT = 3'h5;
  localparam logic [2:0] LC_BUF_CFG = 3'h6;
  localparam logic [2:0] LC_BANK_CTL = 3'h7;
  localparam int RX_EMPTY_BIT = 6;
  localparam int BUF_SIZE_BIT = 1;
  localparam int BANK_LO = 2;
  localparam int SWAP_BIT = 0;
  localparam logic [1:0] BANK_STATION = 2'h0;
  localparam logic [1:0] BANK_HASH = 2'h1;
  localparam logic [1:0] BANK_PORT = 2'h2;
  localparam logic [1:0] BP_DATA_PAIR = 2'h0;
  localparam logic [1:0] BP_TX_PAIR = 2'h1;
  localparam logic [2:0] BP_TX_IDX = 3'h2;
  localparam int TXST_BIT = 7;
  localparam int TX_CNT_W = 7;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] RX_RSVD = 8'h00;
  // ****************************************
  // Buffer memory layout
  // ****************************************
  localparam logic [15:0] MEM_SMALL = 16'h2000;
  localparam logic [15:0] MEM_LARGE = 16'h8000;
  localparam logic [15:0] TX_BANK = 16'h0800;
  localparam logic [15:0] RX_BASE = 16'h1000;
  localparam logic [15:0] RX_HDR_LEN = 16'h0004;
  // ****************************************
  // States and carriers
  // ****************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_LEN_LO = 2'h1, TX_LEN_HI = 2'h3, TX_DATA = 2'h2
  } hrb_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0, RX_DATA = 2'h1, RX_HDR = 2'h3
  } hrb_rx_state_type;
  typedef enum logic [1:0] {RK_NONE, RK_HOST, RK_TX} hrb_rkind_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } hrb_host_req_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic [7:0] status;
  } hrb_rx_in_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } hrb_tx_out_type;
  typedef struct packed {
    logic [14:0] sram_address_bus;
    logic [7:0] sram_data_bus;
    logic sram_data_oe_n;
    logic sram_chip_select_n;
    logic sram_output_enable_n;
    logic sram_write_enable_n;
  } hrb_sram_out_type;
endpackage

// [hrb_top.sv]
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
// How it works
// - Configuration bit picks 8 KB or 32 KB buffer memory.
// - One byte-wide external memory holds transmit and receive packets.
// - Swap clear: low byte of a word is the first stream byte.
// - Swap set: high byte of a word comes first.
// - Swap only acts in 16-bit word mode.
// - Swap applies to every port word both ways, headers included.
// - Only the data port pair is swapped; other registers keep lanes.
// - Four sets of eight registers, byte or word accessible.
// - Link control set always sits at 00H to 07H.
// - Two-bit bank field picks the set at 08H to 0FH.
// - Upper sets: station address, multicast hash, buffer port.
// - Received packet led by status, reserved byte, then 16-bit length.
// - Two-bank transmit area, ring receive area, pointers kept in hardware.
// - One start command sends every chained packet in turn.
// - Data port at upper offset 08H when bank field is 10.
// - In word mode byte access to the data port is unsupported.
// - Drive 15-bit address and 8-bit two-way memory data.
// - Active-low chip select, output enable and write enable.
module hrb_top
  import hrb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Host register port
  input wire hrb_host_req_type host_req,
  output logic [15:0] host_rdata,
  // Bus width strap
  input wire logic word_mode_pin,
  // Network side
  input wire hrb_rx_in_type net_rx,
  output logic net_rx_ready,
  output hrb_tx_out_type net_tx,
  input wire logic net_tx_ready,
  // Buffer memory pins
  output hrb_sram_out_type sram,
  input wire logic [7:0] sram_data_in
);
  // ****************************************
  // Declarations
  // ****************************************
  logic wm_s1, wm;
  logic [7:0] sd_s1, sd;
  logic [7:0] lc [NREG];
  logic [7:0] st [NREG];
  logic [7:0] ht [NREG];
  logic [7:0] bp [NREG];
  logic [1:0] bank;
  logic swap_on, upper, port_hit, port_ok, pw, pr, tx_start;
  logic [15:0] wstream, top;
  logic [7:0] hw0, hw1, pf0, pf1, next_pf0, next_pf1;
  logic [1:0] hw_cnt, pf_cnt, next_pf_cnt;
  logic [15:0] fp, tp, tlen, hr_ptr, wp, hp, rc, rlen;
  logic fb, sb, tx_fly, hr_fly, rx_empty, tx_busy;
  logic [TX_CNT_W-1:0] scnt;
  hrb_tx_state_type txs;
  hrb_rx_state_type rxs;
  logic [7:0] rstat;
  logic [1:0] hcnt;
  logic g_hw, g_hr, g_rx, g_tx, hr_need, tx_need, rx_want, room;
  logic op_we, op_rd;
  logic [15:0] op_addr;
  logic [7:0] op_data, hdr_byte;
  hrb_rkind_type op_kind, rk0, rk1, rk2;
  logic ret_host, ret_tx;

  // Swap is a pure lane exchange, so it costs no cycle either way
  function automatic logic [15:0] swap16(input logic [15:0] w, input logic sw);
    return sw ? {w[7:0], w[15:8]} : w;
  endfunction

  // Ring advance within the receive area
  function automatic logic [15:0] rx_adv(input logic [15:0] p, input logic [15:0] n,
                                         input logic [15:0] t);
    logic [15:0] s;
    s = p + n;
    if (s >= t) begin
      s = s - t + RX_BASE;
    end
    return s;
  endfunction

  // Register byte read, banked above 07H
  function automatic logic [7:0] rb(input logic [2:0] i, input logic up);
    logic [7:0] v;
    v = REG_RST;
    if (!up) begin
      v = lc[i];
      if (i == LC_RX_STAT) begin
        v[RX_EMPTY_BIT] = rx_empty;
      end
    end else begin
      case (bank)
        BANK_STATION: v = st[i];
        BANK_HASH: v = ht[i];
        BANK_PORT: v = (i == BP_TX_IDX) ? {tx_busy, scnt} : bp[i];
        default: v = REG_RST;
      endcase
    end
    return v;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Strap and memory data both arrive from outside the clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wm_s1 <= 1'b0;
      wm <= 1'b0;
      sd_s1 <= 8'h00;
      sd <= 8'h00;
    end else if (ce) begin
      wm_s1 <= word_mode_pin;
      wm <= wm_s1;
      sd_s1 <= sram_data_in;
      sd <= sd_s1;
    end
  end

  // ****************************************
  // Host decode
  // ****************************************
  // Bank field read live, so a change steers the very next access
  always_comb begin
    bank = lc[LC_BANK_CTL][BANK_LO +: 2];
    swap_on = lc[LC_BANK_CTL][SWAP_BIT] & wm;
    upper = host_req.addr[3];
    port_hit = upper && bank == BANK_PORT && host_req.addr[2:1] == BP_DATA_PAIR;
    port_ok = wm ? (host_req.be == 2'h3) : (^host_req.be);
    pw = host_req.wr && port_hit && port_ok;
    pr = host_req.rd && port_hit && port_ok;
    wstream = swap16(host_req.wdata, swap_on);
    tx_busy = txs != TX_IDLE;
    tx_start = host_req.wr && upper && bank == BANK_PORT && host_req.addr[2:1] == BP_TX_PAIR
               && host_req.be[0] && host_req.wdata[TXST_BIT] && !tx_busy
               && host_req.wdata[TX_CNT_W-1:0] != '0;
    top = lc[LC_BUF_CFG][BUF_SIZE_BIT] ? MEM_LARGE : MEM_SMALL;
    rx_empty = (hr_ptr == rc) && (pf_cnt == 2'h0);
  end

  // ****************************************
  // Register sets
  // ****************************************
  // Each byte lane lands on its own register, never swapped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NREG; i++) begin
        lc[i] <= REG_RST;
        st[i] <= REG_RST;
        ht[i] <= REG_RST;
        bp[i] <= REG_RST;
      end
    end else if (ce && host_req.wr && !port_hit) begin
      for (int i = 0; i < 2; i++) begin
        if (host_req.be[i]) begin
          if (!upper) begin
            lc[{host_req.addr[2:1], 1'(i)}] <= host_req.wdata[BYTE_W*i +: BYTE_W];
          end else begin
            case (bank)
              BANK_STATION: st[{host_req.addr[2:1], 1'(i)}] <= host_req.wdata[BYTE_W*i +: BYTE_W];
              BANK_HASH: ht[{host_req.addr[2:1], 1'(i)}] <= host_req.wdata[BYTE_W*i +: BYTE_W];
              BANK_PORT: bp[{host_req.addr[2:1], 1'(i)}] <= host_req.wdata[BYTE_W*i +: BYTE_W];
              default: ;
            endcase
          end
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_rdata <= 16'h0000;
    end else if (ce) begin
      if (pr) begin
        host_rdata <= wm ? swap16({pf1, pf0}, swap_on) : {pf0, pf0};
      end else if (host_req.rd && !port_hit) begin
        host_rdata <= {rb({host_req.addr[2:1], 1'b1}, upper), rb({host_req.addr[2:1], 1'b0}, upper)};
      end else begin
        host_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Memory arbiter
  // ****************************************
  // Host writes first: the holding pair has no spare room
  always_comb begin
    hr_need = !hr_fly && pf_cnt != 2'h2 && hr_ptr != rc;
    tx_need = !tx_fly && (txs == TX_LEN_LO || txs == TX_LEN_HI || (txs == TX_DATA && !net_tx.valid));
    room = rx_adv(wp, 16'h0001, top) != hr_ptr;
    rx_want = (rxs == RX_DATA && net_rx.valid && room) || rxs == RX_HDR;
    g_hw = hw_cnt != 2'h0;
    g_hr = !g_hw && hr_need;
    g_rx = !g_hw && !g_hr && rx_want;
    g_tx = !g_hw && !g_hr && !g_rx && tx_need;
    net_rx_ready = rxs == RX_DATA && g_rx;
    case (hcnt)
      2'h0: hdr_byte = rstat;
      2'h1: hdr_byte = RX_RSVD;
      2'h2: hdr_byte = rlen[7:0];
      default: hdr_byte = rlen[15:8];
    endcase
    op_addr = 16'h0000;
    op_data = 8'h00;
    op_kind = RK_NONE;
    if (g_hw) begin
      op_addr = (fb ? TX_BANK : 16'h0000) + fp;
      op_data = hw0;
    end else if (g_hr) begin
      op_addr = hr_ptr;
      op_kind = RK_HOST;
    end else if (g_rx) begin
      op_addr = (rxs == RX_HDR) ? rx_adv(hp, {14'h0000, hcnt}, top) : wp;
      op_data = (rxs == RX_HDR) ? hdr_byte : net_rx.data;
    end else if (g_tx) begin
      op_addr = (sb ? TX_BANK : 16'h0000) + tp;
      op_kind = RK_TX;
    end
    op_we = (g_hw && fp < TX_BANK) || g_rx;
    op_rd = g_hr || g_tx;
  end

  // Registered pins; reads return three cycles after the grant
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sram <= '{sram_address_bus: 15'h0000, sram_data_bus: 8'h00, sram_data_oe_n: 1'b1,
                sram_chip_select_n: 1'b1, sram_output_enable_n: 1'b1, sram_write_enable_n: 1'b1};
      rk0 <= RK_NONE;
      rk1 <= RK_NONE;
      rk2 <= RK_NONE;
    end else if (ce) begin
      sram.sram_address_bus <= op_addr[14:0];
      sram.sram_data_bus <= op_data;
      sram.sram_data_oe_n <= !op_we;
      sram.sram_chip_select_n <= !(op_we || op_rd);
      sram.sram_output_enable_n <= !op_rd;
      sram.sram_write_enable_n <= !op_we;
      rk0 <= op_kind;
      rk1 <= rk0;
      rk2 <= rk1;
    end
  end

  assign ret_host = rk2 == RK_HOST;
  assign ret_tx = rk2 == RK_TX;

  // ****************************************
  // Host data port
  // ****************************************
  // Stream order of the write word follows the swap setting
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hw0 <= 8'h00;
      hw1 <= 8'h00;
      hw_cnt <= 2'h0;
      fp <= 16'h0000;
      fb <= 1'b0;
    end else if (ce) begin
      if (g_hw) begin
        hw0 <= hw1;
        hw_cnt <= hw_cnt - 2'h1;
        if (fp < TX_BANK) begin
          fp <= fp + 16'h0001;
        end
      end
      if (pw) begin
        hw0 <= wm ? wstream[7:0] : (host_req.be[1] ? host_req.wdata[15:8] : host_req.wdata[7:0]);
        hw1 <= wstream[15:8];
        hw_cnt <= wm ? 2'h2 : 2'h1;
      end
      if (tx_start) begin
        fb <= ~fb;
        fp <= 16'h0000;
      end
    end
  end

  // Read-ahead pair, popped by a port read
  always_comb begin
    next_pf0 = pf0;
    next_pf1 = pf1;
    next_pf_cnt = pf_cnt;
    if (pr) begin
      if (wm || pf_cnt == 2'h0) begin
        next_pf_cnt = 2'h0;
      end else begin
        next_pf0 = pf1;
        next_pf_cnt = pf_cnt - 2'h1;
      end
    end
    if (ret_host) begin
      if (next_pf_cnt == 2'h0) begin
        next_pf0 = sd;
      end else begin
        next_pf1 = sd;
      end
      next_pf_cnt = next_pf_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pf0 <= 8'h00;
      pf1 <= 8'h00;
      pf_cnt <= 2'h0;
      hr_fly <= 1'b0;
      hr_ptr <= RX_BASE;
    end else if (ce) begin
      pf0 <= next_pf0;
      pf1 <= next_pf1;
      pf_cnt <= next_pf_cnt;
      if (g_hr) begin
        hr_fly <= 1'b1;
        hr_ptr <= rx_adv(hr_ptr, 16'h0001, top);
      end else if (ret_host) begin
        hr_fly <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit engine
  // ****************************************
  // Walks the sent bank packet by packet until the count runs out
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txs <= TX_IDLE;
      sb <= 1'b0;
      scnt <= '0;
      tp <= 16'h0000;
      tlen <= 16'h0000;
      tx_fly <= 1'b0;
      net_tx <= '0;
    end else if (ce) begin
      if (net_tx.valid && net_tx_ready) begin
        net_tx.valid <= 1'b0;
      end
      if (g_tx) begin
        tx_fly <= 1'b1;
        tp <= tp + 16'h0001;
      end
      if (tx_start) begin
        sb <= fb;
        scnt <= host_req.wdata[TX_CNT_W-1:0];
        tp <= 16'h0000;
        txs <= TX_LEN_LO;
      end
      if (ret_tx) begin
        tx_fly <= 1'b0;
        case (txs)
          TX_LEN_LO: begin
            tlen[7:0] <= sd;
            txs <= TX_LEN_HI;
          end
          TX_LEN_HI: begin
            tlen[15:8] <= sd;
            if ({sd, tlen[7:0]} != 16'h0000) begin
              txs <= TX_DATA;
            end else begin
              scnt <= scnt - 1'b1;
              txs <= (scnt == 1) ? TX_IDLE : TX_LEN_LO;
            end
          end
          TX_DATA: begin
            net_tx <= '{valid: 1'b1, data: sd, last: tlen == 16'h0001};
            tlen <= tlen - 16'h0001;
            if (tlen == 16'h0001) begin
              scnt <= scnt - 1'b1;
              txs <= (scnt == 1) ? TX_IDLE : TX_LEN_LO;
            end
          end
          default: txs <= TX_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Receive engine
  // ****************************************
  // Header slot is skipped first and filled once length is known
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxs <= RX_IDLE;
      wp <= RX_BASE;
      hp <= RX_BASE;
      rc <= RX_BASE;
      rlen <= 16'h0000;
      rstat <= 8'h00;
      hcnt <= 2'h0;
    end else if (ce) begin
      case (rxs)
        RX_IDLE: begin
          if (net_rx.valid) begin
            wp <= rx_adv(hp, RX_HDR_LEN, top);
            rlen <= 16'h0000;
            rxs <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (g_rx) begin
            wp <= rx_adv(wp, 16'h0001, top);
            rlen <= rlen + 16'h0001;
            if (net_rx.last) begin
              rstat <= net_rx.status;
              hcnt <= 2'h0;
              rxs <= RX_HDR;
            end
          end
        end
        RX_HDR: begin
          if (g_rx) begin
            hcnt <= hcnt + 2'h1;
            if (hcnt == 2'h3) begin
              hp <= wp;
              rc <= wp;
              rxs <= RX_IDLE;
            end
          end
        end
        default: rxs <= RX_IDLE;
      endcase
    end
  end
endmodule

// [hrb_host_model.sv]
`timescale 1ns/1ps
// ****
// Host bus master
// ****
module hrb_host_model
  import hrb_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output hrb_host_req_type host_req,
  input wire logic [15:0] host_rdata
);
  initial host_req = '0;
  // One-cycle write strobe, released at the next edge
  task automatic put(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    host_req <= '0;
  endtask
  // Word read; data taken mid-cycle where it has settled
  task automatic get(input logic [3:0] a, output logic [15:0] d);
    getb(a, 2'h3, d);
  endtask
  // Read with chosen byte lanes
  task automatic getb(input logic [3:0] a, input logic [1:0] be, output logic [15:0] d);
    @(posedge clk_sys);
    host_req <= '{addr: a, wdata: 16'h0000, be: be, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    host_req <= '0;
    @(negedge clk_sys);
    d = host_rdata;
  endtask
endmodule

// [hrb_chk.sv]
`timescale 1ns/1ps
// ****
// Port checker
// ****
module hrb_chk
  import hrb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Host and network
  input wire hrb_host_req_type host_req,
  input wire logic [15:0] host_rdata,
  input wire hrb_tx_out_type net_tx,
  input wire logic net_tx_ready,
  // Memory pins
  input wire hrb_sram_out_type sram
);
  logic big;
  logic [1:0] bank;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Shadow of size and bank; only word writes at 06H are tracked
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      big <= 1'b0;
      bank <= 2'h0;
    end else if (ce && host_req.wr && host_req.addr == 4'h6 && host_req.be == 2'h3) begin
      big <= host_req.wdata[1];
      bank <= host_req.wdata[11:10];
    end
  end
  chk_reset_quiet: assert property (disable iff (1'b0)
    srst && ce |=> sram.sram_chip_select_n && sram.sram_write_enable_n && host_rdata == 16'h0000 && !net_tx.valid)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (ce && !host_req.rd |=> host_rdata == 16'h0000)
    else $error("read data outside read answer");
  chk_bank_none: assert property (ce && host_req.rd && host_req.addr[3] && bank == 2'h3 |=> host_rdata == 16'h0000)
    else $error("unmapped bank answered");
  chk_size_small: assert property (!sram.sram_chip_select_n && !big |-> sram.sram_address_bus[14:13] == 2'h0)
    else $error("address beyond small buffer");
  chk_tx_hold: assert property (net_tx.valid && !net_tx_ready && ce |=> net_tx.valid && $stable(net_tx.data))
    else $error("transmit byte dropped before accept");
  chk_we_oe: assert property (!sram.sram_write_enable_n |-> sram.sram_output_enable_n)
    else $error("write and output enable together");
  chk_we_cs: assert property (!sram.sram_write_enable_n |-> !sram.sram_chip_select_n)
    else $error("write without chip select");
  chk_oe_cs: assert property (!sram.sram_output_enable_n |-> !sram.sram_chip_select_n && sram.sram_data_oe_n)
    else $error("read without select or with bus driven");
  chk_drive_write: assert property (!sram.sram_data_oe_n |-> !sram.sram_write_enable_n)
    else $error("data bus driven outside write");
  cov_tx: cover property (net_tx.valid && net_tx_ready);
  cov_write: cover property ($fell(sram.sram_write_enable_n));
  cov_upper_rd: cover property (host_req.rd && host_req.addr[3]);
endmodule
bind hrb_top hrb_chk u_hrb_chk (.clk_sys(clk_sys), .srst(srst), .ce(ce), .host_req(host_req),
  .host_rdata(host_rdata), .net_tx(net_tx), .net_tx_ready(net_tx_ready), .sram(sram));

// [host_register_bank_and_buffer_port_tb.sv]
`timescale 1ns/1ps
// ****
// Bench top
// ****
module host_register_bank_and_buffer_port_tb;
  import hrb_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic word_mode_pin = 1'b1;
  hrb_host_req_type host_req;
  logic [15:0] host_rdata;
  hrb_rx_in_type net_rx = '0;
  logic net_rx_ready;
  hrb_tx_out_type net_tx;
  logic net_tx_ready = 1'b0;
  hrb_sram_out_type sram;
  logic [7:0] sram_data_in;
  logic [7:0] mem [0:32767];
  logic [7:0] last_q = 8'h00;
  logic [8:0] txq [$];
  int bad_count = 0;
  int checked = 0;
  logic [15:0] rv;
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  hrb_top u_hrb_top (.clk_sys(clk_sys), .srst(srst), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
    .word_mode_pin(word_mode_pin), .net_rx(net_rx), .net_rx_ready(net_rx_ready), .net_tx(net_tx),
    .net_tx_ready(net_tx_ready), .sram(sram), .sram_data_in(sram_data_in));
  hrb_host_model u_hrb_host_model (.clk_sys(clk_sys), .host_req(host_req), .host_rdata(host_rdata));
  // Memory; a released bus shows the inverse of the last byte
  always @(posedge clk_sys) begin
    if (!sram.sram_chip_select_n && !sram.sram_write_enable_n) mem[sram.sram_address_bus] <= sram.sram_data_bus;
    if (!sram.sram_chip_select_n && !sram.sram_output_enable_n) last_q <= mem[sram.sram_address_bus];
  end
  assign sram_data_in = (!sram.sram_chip_select_n && !sram.sram_output_enable_n) ? mem[sram.sram_address_bus] : ~last_q;
  // Consumer accepts every other cycle so the hold is exercised
  always @(posedge clk_sys) begin
    net_tx_ready <= ~net_tx_ready;
    if (net_tx.valid && net_tx_ready) txq.push_back({net_tx.last, net_tx.data});
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic t_reset();
    u_hrb_host_model.get(4'h4, rv);
    chk("link 04 pair", 16'h4000, rv);
    $display("test reset done");
  endtask
  // Same offset in each bank holds its own value; swap set must not touch it
  task automatic t_banks();
    for (int b = 0; b < 3; b++) begin
      u_hrb_host_model.put(4'h6, {4'h0, b[1:0], 2'h1, 8'h00}, 2'h3);
      u_hrb_host_model.put(4'hc, 16'ha0b0 + 16'(b), 2'h3);
    end
    for (int b = 2; b >= 0; b--) begin
      u_hrb_host_model.put(4'h6, {4'h0, b[1:0], 2'h1, 8'h00}, 2'h3);
      u_hrb_host_model.get(4'hc, rv);
      chk("upper 0C", 16'ha0b0 + 16'(b), rv);
      u_hrb_host_model.get(4'h6, rv);
      chk("link 06", {4'h0, b[1:0], 2'h1, 8'h00}, rv);
    end
    u_hrb_host_model.put(4'h6, 16'h0c00, 2'h3);
    u_hrb_host_model.get(4'hc, rv);
    chk("unmapped bank", 16'h0000, rv);
    $display("test banks done");
  endtask
  // Two chained packets, second written swapped, one start
  task automatic t_tx();
    logic [8:0] exp [6] = '{9'h011, 9'h022, 9'h033, 9'h144, 9'h055, 9'h166};
    u_hrb_host_model.put(4'h6, 16'h0800, 2'h3);
    u_hrb_host_model.put(4'h8, 16'h0004, 2'h3);
    u_hrb_host_model.put(4'h8, 16'h2211, 2'h3);
    u_hrb_host_model.put(4'h8, 16'h4433, 2'h3);
    u_hrb_host_model.put(4'h6, 16'h0900, 2'h3);
    u_hrb_host_model.put(4'h8, 16'h0200, 2'h3);
    u_hrb_host_model.put(4'h8, 16'h5566, 2'h3);
    u_hrb_host_model.put(4'ha, 16'h0082, 2'h1);
    for (int i = 0; i < 600 && txq.size() < 6; i++) @(posedge clk_sys);
    chk("tx count", 16'd6, 16'(txq.size()));
    foreach (exp[i]) chk("tx byte", 16'(exp[i]), 16'(txq[i]));
    u_hrb_host_model.get(4'ha, rv);
    chk("tx status", 16'h0000, rv);
    $display("test tx done");
  endtask
  // Received frame read back swapped, header first
  task automatic t_rx();
    logic [7:0] b [4] = '{8'haa, 8'hbb, 8'hcc, 8'hdd};
    logic [15:0] w [4] = '{16'h2000, 16'h0400, 16'haabb, 16'hccdd};
    @(posedge clk_sys);
    foreach (b[i]) begin
      net_rx <= '{1'b1, b[i], i == 3, 8'h20};
      do @(negedge clk_sys); while (net_rx_ready !== 1'b1);
      @(posedge clk_sys);
    end
    net_rx <= '0;
    repeat (60) @(posedge clk_sys);
    u_hrb_host_model.get(4'h4, rv);
    chk("rx empty", 16'h0000, {15'h0, rv[14]});
    foreach (w[i]) begin
      repeat (30) @(posedge clk_sys);
      u_hrb_host_model.get(4'h8, rv);
      chk("rx word", w[i], rv);
    end
    repeat (30) @(posedge clk_sys);
    u_hrb_host_model.get(4'h4, rv);
    chk("rx drained", 16'h0001, {15'h0, rv[14]});
    $display("test rx done");
  endtask
  // Lane widths refused on the data port; byte mode ignores the swap bit
  task automatic t_bytes();
    logic [7:0] s [6] = '{8'h20, 8'h00, 8'h02, 8'h00, 8'h11, 8'h22};
    u_hrb_host_model.getb(4'h8, 2'h1, rv);
    chk("word mode byte read", 16'h0000, rv);
    @(posedge clk_sys);
    word_mode_pin <= 1'b0;
    for (int i = 4; i < 6; i++) begin
      net_rx <= '{1'b1, s[i], i == 5, 8'h20};
      do @(negedge clk_sys); while (net_rx_ready !== 1'b1);
      @(posedge clk_sys);
    end
    net_rx <= '0;
    repeat (60) @(posedge clk_sys);
    u_hrb_host_model.get(4'h8, rv);
    chk("byte mode word read", 16'h0000, rv);
    foreach (s[i]) begin
      repeat (30) @(posedge clk_sys);
      u_hrb_host_model.getb(4'h8, 2'h1, rv);
      chk("byte read", {s[i], s[i]}, rv);
    end
    $display("test bytes done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog far beyond the six hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_banks();
    t_tx();
    t_rx();
    t_bytes();
    end_sim();
  end
endmodule
